// ===== verilog/otpti_bank.sv
// otpti_bank: trace registers, user nonvolatile data, lock/crc bytes and the
// continuous check of the writable array
// assumes: serial framing outside delivers one command per req_valid pulse on
// clk; init_done_flag and the factory image come from logic on the same clock,
// so none of them passes a synchroniser; otp_load is a one-cycle pulse that
// arrives only while the image on fac_image is settled; ce low freezes every
// flop, including the answer strobe
`timescale 1ns/1ps

module otpti_bank
    import otpti_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // register command port
    input wire logic req_valid,
    input wire otpti_req_t req,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    // device state
    input wire logic init_done_flag,
    input wire logic otp_load,
    input wire otpti_fac_t fac_image,
    // integrity status
    output logic factory_crc_err,
    output logic rw_crc_err,
    output logic [1:0] user_locked
);

    // ==========================================================
    // storage
    otpti_fac_t fac; // shadow of the factory array
    logic [7:0] user_nv_data [0:USER_BYTES-1]; // user nonvolatile data bytes
    otpti_lock_t user_lock [0:1]; // user block lock/crc bytes
    logic [7:0] nv_wr_en; // nonvolatile write enable register
    logic fchk_pend; // factory check one cycle after load
    logic [3:0] rw_ref; // reference crc of writable array
    otpti_mon_t mon_state;
    otpti_mon_t next_mon_state;

    // ==========================================================
    // address decode
    // offsets are taken by subtraction so that one compare per block
    // bounds the window; the lower bound check keeps an address below the
    // base from wrapping into the block
    // block 2 entries follow block 1 entries in the flat data array
    wire logic [7:0] off0 = req.addr - OFS_USER0_BASE;
    wire logic [7:0] off1 = req.addr - OFS_USER1_BASE;
    wire logic in_blk0 = (req.addr >= OFS_USER0_BASE) && (off0 < USER_SPAN);
    wire logic in_blk1 = (req.addr >= OFS_USER1_BASE) && (off1 < USER_SPAN);
    wire logic user_sel = in_blk0 || in_blk1;
    wire logic [4:0] user_idx = in_blk1 ? 5'(off1 + 8'(USER_BLK_LEN)) : off0[4:0];
    wire logic blk_locked = in_blk1 ? user_lock[1].locked : user_lock[0].locked;
    wire logic open_area = !init_done_flag;
    wire logic wr_cmd = req_valid && req.we;
    // user byte write, only while open and the block is unlocked
    wire logic wr_user = wr_cmd && user_sel && open_area && !blk_locked;
    wire logic wr_nv_en = wr_cmd && (req.addr == OFS_NV_WR_EN) && open_area;

    // ==========================================================
    // read data mux and access class
    // these three are pure functions of the command in hand and of the
    // stored state; they hold no state of their own
    logic [7:0] rd_byte; // current contents of the addressed register
    logic mapped; // address is in the user-accessible map right now
    logic read_only; // register ignores writes

    // selects contents; factory and user areas vanish once init is done
    // unmapped is decided last so that one zero forcing covers both the
    // holes in the map and the areas closed by init done
    // reserved bits of the status byte read as zero; lock bytes have none and read whole
    always_comb begin
        rd_byte = ZERO_BYTE;
        mapped = 1'b1;
        read_only = 1'b1;
        if (user_sel) begin
            rd_byte = user_nv_data[user_idx];
            read_only = blk_locked;
        end else begin
            case (req.addr)
                OFS_NV_WR_EN: begin
                    rd_byte = nv_wr_en;
                    read_only = 1'b0;
                end
                OFS_INTEG_STATUS: rd_byte = {5'h00, user_lock[1].locked,
                                             factory_crc_err, rw_crc_err};
                OFS_USER0_LOCK: rd_byte = user_lock[0];
                OFS_USER1_LOCK: rd_byte = user_lock[1];
                OFS_SERIAL3: rd_byte = fac.serial3;
                OFS_SERIAL4: rd_byte = fac.serial4;
                OFS_WAFER_NUM: rd_byte = fac.wafer_number;
                OFS_WAFER_X: rd_byte = fac.wafer_x_coord;
                OFS_WAFER_Y: rd_byte = fac.wafer_y_coord;
                OFS_LOT_LOW: rd_byte = fac.wafer_lot_low;
                OFS_LOT_HIGH: rd_byte = fac.wafer_lot_high;
                OFS_LOCK_A: rd_byte = fac.lock_a;
                OFS_LOCK_B: rd_byte = fac.lock_b;
                OFS_LOCK_C: rd_byte = fac.lock_c;
                OFS_LOCK_D: rd_byte = fac.lock_d;
                OFS_LOCK_E: rd_byte = fac.lock_e;
                OFS_LOCK_F: rd_byte = fac.lock_f;
                default: mapped = 1'b0;
            endcase
        end
        // status register stays visible after init, the rest closes
        if (!open_area && (req.addr != OFS_INTEG_STATUS)) begin
            mapped = 1'b0;
        end
        if (!mapped) begin
            rd_byte = ZERO_BYTE;
        end
    end

    // answer byte: executed writes echo the data, others show contents
    // an executed write is exactly one that the storage below takes, so the
    // echo can never report a byte that was not stored; a refused write
    // (read only, locked, closed or unmapped) shows what the read would show
    wire logic wr_done = wr_user || wr_nv_en; // write taken by storage
    wire logic [7:0] next_rsp = wr_done ? req.wdata : rd_byte;

    // ==========================================================
    // crc over the user blocks and the whole writable array
    logic [3:0] blk_crc [0:1]; // per block, used on commit
    logic [3:0] scan_crc; // whole user array, used by the monitor

    // folds every byte through the 4-bit generator from the zero seed
    // the fold is one long combinational chain over thirty bytes; it is
    // only sampled on commit and by the monitor, both of which tolerate a
    // full cycle, and the array changes only by host writes
    // bytes go in ascending address order, msb first within each byte
    always_comb begin
        blk_crc[0] = CRC_SEED;
        blk_crc[1] = CRC_SEED;
        scan_crc = CRC_SEED;
        for (int i = 0; i < USER_BLK_LEN; i++) begin
            blk_crc[0] = otpti_crc_byte(blk_crc[0], user_nv_data[i]);
            blk_crc[1] = otpti_crc_byte(blk_crc[1], user_nv_data[i+USER_BLK_LEN]);
        end
        for (int i = 0; i < USER_BYTES; i++) begin
            scan_crc = otpti_crc_byte(scan_crc, user_nv_data[i]);
        end
    end

    // factory crc over the trace bytes held here, blocks c and d
    // the other factory blocks live outside this bank and are checked there;
    // their lock bytes are only shown to the host
    wire logic [3:0] fac_crc_c = otpti_crc_byte(otpti_crc_byte(otpti_crc_byte(
        otpti_crc_byte(otpti_crc_byte(CRC_SEED, fac.serial3), fac.serial4),
        fac.wafer_number), fac.wafer_x_coord), fac.wafer_y_coord);
    wire logic [3:0] fac_crc_d = otpti_crc_byte(otpti_crc_byte(CRC_SEED,
        fac.wafer_lot_low), fac.wafer_lot_high);
    wire logic fac_bad = (fac_crc_c != fac.lock_c.crc) ||
                         (fac_crc_d != fac.lock_d.crc);

    // ==========================================================
    // command answer
    // one answer for every command, the cycle after it is taken
    // nothing is refused: reserved, unmapped and read-only addresses all
    // answer, only the byte differs; the byte holds until the next answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data <= ZERO_BYTE;
        end else if (ce) begin
            rsp_valid <= req_valid;
            if (req_valid) begin
                rsp_data <= next_rsp;
            end
        end
    end

    // ==========================================================
    // factory shadow, loaded from the nonvolatile image
    // the image is read only to the host; only the load pulse changes it
    // the check runs one cycle after the load so that it sees the new
    // shadow, and its flag is overwritten by every later load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fac <= '0;
            fchk_pend <= 1'b0;
            factory_crc_err <= 1'b0;
        end else if (ce) begin
            fchk_pend <= otp_load;
            if (otp_load) begin
                fac <= fac_image;
            end
            if (fchk_pend) begin
                factory_crc_err <= fac_bad;
            end
        end
    end

    // ==========================================================
    // user data bytes, one write port per entry
    // each entry has its own flop process so that an entry is written only
    // when the decoded index names it; writes stop at init done and once the
    // owning block is locked
    genvar gi;
    generate
        for (gi = 0; gi < USER_BYTES; gi++) begin : g_user
            // takes a host write addressed to this entry
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    user_nv_data[gi] <= ZERO_BYTE;
                end else if (ce && wr_user && (user_idx == 5'(gi))) begin
                    user_nv_data[gi] <= req.wdata;
                end
            end
        end
    endgenerate

    // ==========================================================
    // nonvolatile write enable and commit
    wire logic [1:0] commit_req = {nv_wr_en[COMMIT_BLK1_BIT], nv_wr_en[COMMIT_BLK0_BIT]};

    // write stores the whole byte; commit bits self-clear on every cycle without a write
    // a host write in the same cycle as the self-clear wins, so a fresh
    // commit request is never lost; the cleared bits then read back as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nv_wr_en <= ZERO_BYTE;
        end else if (ce) begin
            if (wr_nv_en) begin
                nv_wr_en <= req.wdata;
            end else begin
                nv_wr_en[COMMIT_BLK0_BIT] <= 1'b0;
                nv_wr_en[COMMIT_BLK1_BIT] <= 1'b0;
            end
        end
    end

    // lock bytes written automatically by the commit of their block
    // the crc is taken from the array as it stands on the commit cycle;
    // a second commit of a locked block changes nothing
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lock
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    user_lock[gi] <= '0;
                end else if (ce && commit_req[gi] && !user_lock[gi].locked) begin
                    user_lock[gi].locked <= 1'b1;
                    user_lock[gi].block_identifier <= USER_BLOCK_ID;
                    user_lock[gi].crc <= blk_crc[gi];
                end
            end
            assign user_locked[gi] = user_lock[gi].locked;
        end
    endgenerate

    // ==========================================================
    // writable array monitor
    // arms a reference on init done, then compares every cycle
    // the reference is taken one cycle after init done so that a write
    // taken on the same edge as the flag is already in the array;
    // dropping init done returns to config but leaves the error flag set
    always_comb begin
        next_mon_state = mon_state;
        case (mon_state)
            MON_CONFIG: if (init_done_flag) next_mon_state = MON_ARM;
            MON_ARM: next_mon_state = MON_WATCH;
            MON_WATCH: if (!init_done_flag) next_mon_state = MON_CONFIG;
            default: next_mon_state = MON_CONFIG;
        endcase
    end

    // reference capture and sticky mismatch flag
    // the flag has no clear but reset, so no set and clear can meet;
    // writes are closed while it watches, so any drift is a fault
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mon_state <= MON_CONFIG;
            rw_ref <= CRC_SEED;
            rw_crc_err <= 1'b0;
        end else if (ce) begin
            mon_state <= next_mon_state;
            if (mon_state == MON_ARM) begin
                rw_ref <= scan_crc;
            end
            if ((mon_state == MON_WATCH) && init_done_flag && (scan_crc != rw_ref)) begin
                rw_crc_err <= 1'b1;
            end
        end
    end

endmodule : otpti_bank

// ===== verilog/otpti_pkg.sv
// otpti_pkg: constants, carriers and helpers for the trace and integrity bank
// assumes: one byte-wide register command port, 8-bit addresses
package otpti_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_USER0_BASE = 8'h40; // user data block 1, first byte
    localparam logic [7:0] OFS_USER0_LOCK = 8'h4F; // user block 1 lock/crc byte
    localparam logic [7:0] OFS_USER1_BASE = 8'h50; // user data block 2, first byte
    localparam logic [7:0] OFS_USER1_LOCK = 8'h5F; // user_block2_lock_crc
    localparam logic [7:0] OFS_NV_WR_EN = 8'h38; // nonvolatile write enable
    localparam logic [7:0] OFS_INTEG_STATUS = 8'h39; // integrity status, read only
    localparam logic [7:0] OFS_LOCK_A = 8'hAF;
    localparam logic [7:0] OFS_LOCK_B = 8'hBF;
    localparam logic [7:0] OFS_SERIAL3 = 8'hC9;
    localparam logic [7:0] OFS_SERIAL4 = 8'hCA;
    localparam logic [7:0] OFS_WAFER_NUM = 8'hCB;
    localparam logic [7:0] OFS_WAFER_X = 8'hCC;
    localparam logic [7:0] OFS_WAFER_Y = 8'hCD;
    localparam logic [7:0] OFS_LOCK_C = 8'hCF;
    localparam logic [7:0] OFS_LOT_LOW = 8'hD0;
    localparam logic [7:0] OFS_LOT_HIGH = 8'hD1;
    localparam logic [7:0] OFS_LOCK_D = 8'hDF;
    localparam logic [7:0] OFS_LOCK_E = 8'hEF;
    localparam logic [7:0] OFS_LOCK_F = 8'hFF;

    // ==========================================================
    // sizes and field values
    localparam int USER_BLK_LEN = 15; // data bytes per user block
    localparam int USER_BYTES = 30; // both user blocks
    localparam logic [7:0] USER_SPAN = 8'h0F; // bytes from base to lock byte
    localparam logic [2:0] USER_BLOCK_ID = 3'h0; // user lock bytes carry id zero
    localparam logic [7:0] ZERO_BYTE = 8'h00; // answer for unmapped addresses
    localparam logic [3:0] CRC_POLY = 4'h9; // x^4 + x^3 + 1
    localparam logic [3:0] CRC_SEED = 4'h0;
    localparam int COMMIT_BLK0_BIT = 0; // nv write enable: commit user block 1
    localparam int COMMIT_BLK1_BIT = 1; // nv write enable: commit user block 2

    // ==========================================================
    // carriers
    typedef struct packed {
        logic we; // 1 = write command
        logic [7:0] addr; // register address
        logic [7:0] wdata; // write data
    } otpti_req_t;

    // lock/crc byte layout
    typedef struct packed {
        logic locked; // bit 7
        logic [2:0] block_identifier; // bits 6:4
        logic [3:0] crc; // bits 3:0
    } otpti_lock_t;

    // factory nonvolatile image as read from the array
    typedef struct packed {
        logic [7:0] serial3;
        logic [7:0] serial4;
        logic [7:0] wafer_number;
        logic [7:0] wafer_x_coord;
        logic [7:0] wafer_y_coord;
        logic [7:0] wafer_lot_low;
        logic [7:0] wafer_lot_high;
        otpti_lock_t lock_a;
        otpti_lock_t lock_b;
        otpti_lock_t lock_c;
        otpti_lock_t lock_d;
        otpti_lock_t lock_e;
        otpti_lock_t lock_f;
    } otpti_fac_t;

    // monitor of the writable array
    typedef enum logic [1:0] {MON_CONFIG, MON_ARM, MON_WATCH} otpti_mon_t;

    // ==========================================================
    // one byte into the 4-bit crc, msb first
    function automatic logic [3:0] otpti_crc_byte(input logic [3:0] crc_in,
                                                  input logic [7:0] data);
        logic [3:0] c;
        c = crc_in;
        for (int b = 7; b >= 0; b--) begin
            if (c[3] ^ data[b]) begin
                c = {c[2:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[2:0], 1'b0};
            end
        end
        return c;
    endfunction : otpti_crc_byte

endpackage : otpti_pkg

// ===== tb/otpti_bank_asserts.sv
// checker for otpti_bank: answer timing, closed map, commit and error flags
// assumes: ce is high whenever commands are presented
`timescale 1ns/1ps

module otpti_bank_chk
    import otpti_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // command port
    input wire logic req_valid,
    input wire otpti_req_t req,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    // state and flags
    input wire logic init_done_flag,
    input wire logic factory_crc_err,
    input wire logic rw_crc_err,
    input wire logic [1:0] user_locked
);
    // ==========================================================
    // sequences
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a command taken at this edge
    sequence s_take;
        ce && req_valid;
    endsequence
    // a commit of user block 1 while the map is open
    sequence s_commit1;
        s_take ##0 req.we && req.addr == OFS_NV_WR_EN && req.wdata[0] && !init_done_flag;
    endsequence

    // ==========================================================
    // properties
    chk_rsp_follows: assert property (s_take |=> rsp_valid)
        else $error("command not answered next cycle");
    chk_rsp_quiet: assert property (ce && !req_valid |=> !rsp_valid)
        else $error("answer without command");
    chk_unmapped_zero: assert property (s_take ##0 req.addr < OFS_NV_WR_EN
        |=> rsp_data == ZERO_BYTE) else $error("unmapped address gave nonzero byte");
    chk_closed_after_init: assert property (s_take ##0 init_done_flag &&
        req.addr != OFS_INTEG_STATUS |=> rsp_data == ZERO_BYTE)
        else $error("map open after init done");
    chk_user_write_echo: assert property (s_take ##0 req.we && !init_done_flag &&
        !user_locked[0] && req.addr >= OFS_USER0_BASE && req.addr < OFS_USER0_LOCK
        |=> rsp_data == $past(req.wdata)) else $error("user write not echoed");
    chk_commit_locks: assert property (s_commit1 |-> ##2 user_locked[0])
        else $error("commit did not lock block");
    chk_lock_kept: assert property (user_locked[0] |=> user_locked[0])
        else $error("lock flag dropped");
    chk_rw_err_sticky: assert property (rw_crc_err |=> rw_crc_err)
        else $error("array error flag cleared");
    chk_status_byte: assert property (s_take ##0 !req.we &&
        req.addr == OFS_INTEG_STATUS
        |=> rsp_data == {5'h00, $past(user_locked[1]), $past(factory_crc_err),
        $past(rw_crc_err)}) else $error("status byte wrong");
endmodule : otpti_bank_chk

bind otpti_bank otpti_bank_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid),
    .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done_flag(init_done_flag),
    .factory_crc_err(factory_crc_err), .rw_crc_err(rw_crc_err), .user_locked(user_locked));

// ===== tb/otpti_host.sv
// host model: issues one register command and collects its answer
// assumes: answer is registered on the taking edge and is read just after that edge
`timescale 1ns/1ps

module otpti_host
    import otpti_pkg::*;
(
    // clock
    input wire logic clk,
    // command port
    output logic req_valid,
    output otpti_req_t req,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data
);
    // idle until the first command
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // present, hold over the taking edge, then release and collect
    task automatic xfer(input logic we, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ok);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req = {we, addr, wdata};
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        // released lines must not look like the last command
        req = ~req;
        ok = rsp_valid;
        rdata = rsp_data;
    endtask : xfer
endmodule : otpti_host

// ===== tb/otp_trace_and_register_integrity_tb.sv
// testbench for otpti_bank: factory, user, reserved and closed-map access
// assumes: host model otpti_host drives the command port
`timescale 1ns/1ps

module otp_trace_and_register_integrity_tb;
    import otpti_pkg::*;
    // ==========================================================
    // signals
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, init_done_flag = 1'b0, otp_load = 1'b0;
    logic req_valid, rsp_valid, factory_crc_err, rw_crc_err, ok;
    logic [1:0] user_locked;
    logic [7:0] rsp_data, rd, crc, b;
    otpti_req_t req;
    otpti_fac_t img;
    int fail_count = 0, checked = 0, cycles = 0;
    logic [7:0] fac_adr [13] = '{8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD0, 8'hD1,
        8'hAF, 8'hBF, 8'hCF, 8'hDF, 8'hEF, 8'hFF};

    otpti_bank DUT (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done_flag(init_done_flag),
        .otp_load(otp_load), .fac_image(img), .factory_crc_err(factory_crc_err),
        .rw_crc_err(rw_crc_err), .user_locked(user_locked));
    otpti_host host (.clk(clk), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));

    // ==========================================================
    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            complete_run();
        end
    end

    // ==========================================================
    // helpers
    // 4-bit crc, msb first, x^4+x^3+1
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [3:0] r;
        r = c[3:0];
        for (int k = 7; k >= 0; k--) begin
            r = (r[3] ^ d[k]) ? ({r[2:0], 1'b0} ^ 4'h9) : {r[2:0], 1'b0};
        end
        return {4'h0, r};
    endfunction : crc_step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one command; any skips the data compare
    task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] w,
                       input logic [7:0] exp, input bit any = 0);
        host.xfer(we, a, w, rd, ok);
        chk({7'h00, ok}, 8'h01);
        if (!any) begin
            chk(rd, exp);
        end
    endtask : acc
    task automatic load();
        @(posedge clk);
        #1 otp_load = 1'b1;
        @(posedge clk);
        #1 otp_load = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : load
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // main sequence
    initial begin
        img = '0;
        img[103:48] = {8'h12, 8'h34, 8'h56, 8'h07, 8'h09, 8'hA1, 8'h0B};
        img.lock_a = 8'h90;
        img.lock_b = 8'hA0;
        crc = 8'h00;
        for (int i = 0; i < 5; i++) crc = crc_step(crc, img[103-8*i -: 8]);
        img.lock_c = {4'hB, crc[3:0]};
        crc = crc_step(crc_step(8'h00, img.wafer_lot_low), img.wafer_lot_high);
        img.lock_d = {4'hD, crc[3:0]};
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        load();
        chk({7'h00, factory_crc_err}, 8'h00);
        for (int i = 0; i < 13; i++) begin
            acc(0, fac_adr[i], 8'h00, img[103-8*i -: 8]);
        end
        acc(1, OFS_WAFER_NUM, 8'hFF, img.wafer_number);
        acc(0, OFS_WAFER_NUM, 8'h00, img.wafer_number);
        acc(1, OFS_LOCK_A, 8'h00, img.lock_a);
        img.lock_c.crc = ~img.lock_c.crc;
        load();
        chk({7'h00, factory_crc_err}, 8'h01);
        acc(0, OFS_INTEG_STATUS, 8'h00, 8'h02);
        img.lock_c.crc = ~img.lock_c.crc;
        load();
        crc = 8'h00;
        for (int i = 0; i < 15; i++) begin
            b = 8'h03 + 8'(i) * 8'h1D;
            crc = crc_step(crc, b);
            acc(1, OFS_USER0_BASE + 8'(i), b, b);
        end
        acc(0, OFS_USER0_BASE + 8'h0E, 8'h00, 8'h03 + 8'h0E * 8'h1D);
        acc(1, OFS_NV_WR_EN, 8'h01, 8'h01);
        @(posedge clk);
        #1;
        chk({6'h00, user_locked}, 8'h01);
        acc(0, OFS_USER0_LOCK, 8'h00, {4'h8, crc[3:0]});
        acc(0, OFS_NV_WR_EN, 8'h00, 8'h00);
        acc(1, OFS_USER0_BASE, 8'hEE, 8'h03);
        acc(1, OFS_NV_WR_EN, 8'h02, 8'h02);
        acc(0, OFS_USER1_LOCK, 8'h00, 8'h80);
        acc(0, OFS_INTEG_STATUS, 8'h00, 8'h04);
        acc(0, 8'hC0, 8'h00, 8'h00, 1);
        acc(1, OFS_NV_WR_EN, 8'h00, 8'h00);
        acc(0, 8'h10, 8'h00, 8'h00);
        acc(1, 8'h10, 8'hA5, 8'h00);
        acc(0, 8'h10, 8'h00, 8'h00);
        // clock enable low: a presented command is not taken and not answered
        @(posedge clk);
        #1 ce = 1'b0;
        host.xfer(1'b0, OFS_INTEG_STATUS, 8'h00, rd, ok);
        chk({7'h00, ok}, 8'h00);
        ce = 1'b1;
        chk({6'h00, user_locked}, 8'h03);
        init_done_flag = 1'b1;
        repeat (3) @(posedge clk);
        acc(0, OFS_WAFER_NUM, 8'h00, 8'h00);
        acc(1, OFS_USER1_BASE, 8'h5A, 8'h00);
        repeat (20) @(posedge clk);
        acc(0, OFS_INTEG_STATUS, 8'h00, 8'h04);
        chk({7'h00, rw_crc_err}, 8'h00);
        init_done_flag = 1'b0;
        acc(0, OFS_USER1_BASE, 8'h00, 8'h00);
        complete_run();
    end
endmodule : otp_trace_and_register_integrity_tb
